// ===== design/dsf_pkg.sv
package dsf_pkg;

  // Storage depth choices per buffer
  localparam int DEPTH_SMALL = 64;
  localparam int DEPTH_LARGE = 256;
  localparam int DEPTH_DEF = DEPTH_SMALL;
  // Widest pointer: 256 words plus one wrap bit
  localparam int PTR_MAX_W = 9;
  // Near-edge window, in locations from full or empty
  localparam int EDGE_GAP = 8;
  // Push ticks after reset release before space is offered
  localparam int SPACE_RISE_TICKS = 2;
  // Pop-side pointer stages ahead of the output register
  localparam int POP_SYNC_STAGES = 2;
  localparam int PUSH_SYNC_STAGES = 2;
  localparam int NUM_BUF = 2;

  // APB register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_FLAGS = 12'h004;
  localparam logic [11:0] REG_EV_STAT = 12'h008;
  localparam logic [11:0] REG_EV_CLR = 12'h00c;
  localparam logic [11:0] REG_EV_EN = 12'h010;
  localparam logic [11:0] REG_LEVEL = 12'h014;

  // CTRL: bit n holds buffer n in reset
  localparam logic [1:0] CTRL_RST_VAL = 2'h0;
  // FLAGS: one nibble per buffer
  localparam int FLG_SPACE = 0;
  localparam int FLG_OUT = 1;
  localparam int FLG_HALF = 2;
  localparam int FLG_EDGE = 3;
  localparam int FLG_STRIDE = 4;
  // Events: one nibble per buffer
  localparam int EV_OVF = 0;
  localparam int EV_UNF = 1;
  localparam int EV_HALF = 2;
  localparam int EV_FULL = 3;
  localparam int EV_STRIDE = 4;
  localparam logic [7:0] EV_EN_RST_VAL = 8'h00;
  // LEVEL: stored count of buffer n at bit n*16
  localparam int LVL_STRIDE = 16;

  typedef logic [7:0] dsf_ev_t;

  typedef enum logic [2:0] {
    PS_HOLD = 3'b001,
    PS_ARM = 3'b010,
    PS_RUN = 3'b100
  } dsf_push_st_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dsf_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsf_apb_rsp_s;

  typedef struct packed {
    logic reset_n;
    logic data_in;
    logic pop_enable;
    logic pop_clock;
    logic push_enable;
    logic push_clock;
  } dsf_pin_in_s;

  typedef struct packed {
    logic data_out;
    logic out_ready_flag;
    logic space_avail_flag;
    logic half_level_flag;
    logic near_edge_flag;
  } dsf_pin_out_s;

  function automatic logic [PTR_MAX_W-1:0] dsf_bin2gray(
    input logic [PTR_MAX_W-1:0] b
  );
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_MAX_W-1:0] dsf_gray2bin(
    input logic [PTR_MAX_W-1:0] g
  );
    logic [PTR_MAX_W-1:0] b;
    b[PTR_MAX_W-1] = g[PTR_MAX_W-1];
    for (int i = PTR_MAX_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ===== design/dsf_pin_sync.sv
`timescale 1ns/1ps
module dsf_pin_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input logic clk,
  input logic rst,
  // Raw pins
  input logic [W-1:0] pin,
  // Settled levels and rising-edge pulses
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] lvl_d;
  logic [W-1:0] rise_q;
  logic [W-1:0] rise_d;

  // A change counts only once stages two and three agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
    rise_d = lvl_d & ~lvl_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
      rise_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      rise_q <= rise_d;
    end
  end

  assign lvl = lvl_q;
  assign rise = rise_q;
endmodule

// ===== design/dsf_store.sv
`timescale 1ns/1ps
module dsf_store #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // Clock
  input logic clk,
  // Write port
  input logic wr_en,
  input logic [AW-1:0] wr_addr,
  input logic wr_bit,
  // Read port, combinational
  input logic [AW-1:0] rd_addr,
  output logic rd_bit
);
  logic mem [DEPTH];

  // No reset: contents are dead until the pointers say otherwise
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_bit;
    end
  end

  assign rd_bit = mem[rd_addr];
endmodule

// ===== design/dsf_top.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module dsf_top #(
  parameter int DEPTH = dsf_pkg::DEPTH_DEF
) (
  // Core clock and reset
  input logic CORE_CLK,
  input logic RST,
  // APB slave
  input dsf_pkg::dsf_apb_req_s APB_REQ,
  output dsf_pkg::dsf_apb_rsp_s APB_RSP,
  // Buffer pins
  input dsf_pkg::dsf_pin_in_s BUF_IN [dsf_pkg::NUM_BUF],
  output dsf_pkg::dsf_pin_out_s BUF_OUT [dsf_pkg::NUM_BUF],
  // Interrupt
  output logic IRQ
);
  import dsf_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] FULL_CNT = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_CNT = PW'(DEPTH / 2);
  localparam logic [PW-1:0] EDGE_LO = PW'(EDGE_GAP);
  localparam logic [PW-1:0] EDGE_HI = PW'(DEPTH - EDGE_GAP);

  logic [NUM_BUF-1:0] ctrl_q;
  logic [NUM_BUF-1:0] ctrl_d;
  dsf_ev_t ev;
  logic [NUM_BUF*FLG_STRIDE-1:0] flags;
  logic [PW-1:0] level [NUM_BUF];

  genvar g;
  // Each buffer is its own generate instance; nothing is shared
  for (g = 0; g < NUM_BUF; g++) begin : gen_buf
    logic [5:0] pin_lvl;
    logic [5:0] pin_rise;
    logic brst;
    logic push_tick;
    logic pop_tick;
    logic push_en;
    logic pop_en;
    logic din;
    logic rd_bit;
    logic wr_do;
    logic take;
    logic load;
    logic mem_avail;
    logic [PW-1:0] rbin;
    logic [PW-1:0] wbin;
    logic [PW-1:0] stored_d;
    // Full-width conversion results, cut down to the pointer width
    logic [PTR_MAX_W-1:0] rbin_x;
    logic [PTR_MAX_W-1:0] wbin_x;
    logic [PTR_MAX_W-1:0] wgray_x;
    logic [PTR_MAX_W-1:0] rgray_x;
    // Push side
    dsf_push_st_e pst_q;
    dsf_push_st_e pst_d;
    logic [PW-1:0] wptr_q;
    logic [PW-1:0] wptr_d;
    logic [PW-1:0] wgray_q;
    logic [PW-1:0] wgray_d;
    logic [PW-1:0] rsync1_q;
    logic [PW-1:0] rsync1_d;
    logic [PW-1:0] rsync2_q;
    logic [PW-1:0] rsync2_d;
    logic ir_q;
    logic ir_d;
    // Pop side
    logic [PW-1:0] rptr_q;
    logic [PW-1:0] rptr_d;
    logic [PW-1:0] rgray_q;
    logic [PW-1:0] rgray_d;
    logic [PW-1:0] wsync1_q;
    logic [PW-1:0] wsync1_d;
    logic [PW-1:0] wsync2_q;
    logic [PW-1:0] wsync2_d;
    logic or_q;
    logic or_d;
    logic dout_q;
    logic dout_d;
    // Level flags
    logic hf_q;
    logic hf_d;
    logic edge_q;
    logic edge_d;

    // Push and pop clocks arrive as pins; their rising edges become tick pulses
    dsf_pin_sync #(
      .W(6)
    ) u_sync (
      .clk(CORE_CLK),
      .rst(RST),
      .pin(BUF_IN[g]),
      .lvl(pin_lvl),
      .rise(pin_rise)
    );

    assign push_tick = pin_rise[0];
    assign push_en = pin_lvl[1];
    assign pop_tick = pin_rise[2];
    assign pop_en = pin_lvl[3];
    assign din = pin_lvl[4];
    // Pin reset, global reset or software hold
    assign brst = RST | ~pin_lvl[5] | ctrl_q[g];

    dsf_store #(
      .DEPTH(DEPTH),
      .AW(AW)
    ) u_store (
      .clk(CORE_CLK),
      .wr_en(wr_do),
      .wr_addr(wptr_q[AW-1:0]),
      .wr_bit(din),
      .rd_addr(rptr_q[AW-1:0]),
      .rd_bit(rd_bit)
    );

    // Push side, advancing only on push ticks
    always_comb begin
      rbin_x = dsf_gray2bin(PTR_MAX_W'(rsync2_q));
      rbin = rbin_x[PW-1:0];
      wr_do = push_tick & push_en & ir_q;
      wptr_d = wptr_q + PW'(wr_do);
      wgray_x = dsf_bin2gray(PTR_MAX_W'(wptr_q));
      wgray_d = wgray_x[PW-1:0];
      pst_d = pst_q;
      ir_d = ir_q;
      rsync1_d = rsync1_q;
      rsync2_d = rsync2_q;
      if (push_tick) begin
        rsync1_d = rgray_q;
        rsync2_d = rsync1_q;
        case (pst_q)
          PS_HOLD: pst_d = PS_ARM;
          PS_ARM: pst_d = PS_RUN;
          PS_RUN: pst_d = PS_RUN;
          default: pst_d = PS_HOLD;
        endcase
        // Space is offered from the second tick after release on
        ir_d = (pst_d == PS_RUN) && ((wptr_d - rbin) != FULL_CNT);
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (brst) begin
        pst_q <= PS_HOLD;
        wptr_q <= '0;
        wgray_q <= '0;
        rsync1_q <= '0;
        rsync2_q <= '0;
        ir_q <= 1'b0;
      end else begin
        pst_q <= pst_d;
        wptr_q <= wptr_d;
        wgray_q <= wgray_d;
        rsync1_q <= rsync1_d;
        rsync2_q <= rsync2_d;
        ir_q <= ir_d;
      end
    end

    // Pop side: two pointer stages, then the output register as the third
    always_comb begin
      wbin_x = dsf_gray2bin(PTR_MAX_W'(wsync2_q));
      wbin = wbin_x[PW-1:0];
      mem_avail = (wbin != rptr_q);
      take = pop_tick & pop_en & or_q;
      load = pop_tick & (~or_q | take) & mem_avail;
      rptr_d = rptr_q + PW'(load);
      rgray_x = dsf_bin2gray(PTR_MAX_W'(rptr_q));
      rgray_d = rgray_x[PW-1:0];
      wsync1_d = wsync1_q;
      wsync2_d = wsync2_q;
      or_d = or_q;
      dout_d = dout_q;
      if (pop_tick) begin
        wsync1_d = wgray_q;
        wsync2_d = wsync1_q;
        or_d = mem_avail | (or_q & ~take);
      end
      if (load) begin
        dout_d = rd_bit;
      end
    end

    always_ff @(posedge CORE_CLK) begin
      if (brst) begin
        rptr_q <= '0;
        rgray_q <= '0;
        wsync1_q <= '0;
        wsync2_q <= '0;
        or_q <= 1'b0;
        dout_q <= 1'b0;
      end else begin
        rptr_q <= rptr_d;
        rgray_q <= rgray_d;
        wsync1_q <= wsync1_d;
        wsync2_q <= wsync2_d;
        or_q <= or_d;
        dout_q <= dout_d;
      end
    end

    // Level flags see the exact stored count; the output bit is excluded
    always_comb begin
      stored_d = wptr_d - rptr_d;
      hf_d = (stored_d >= HALF_CNT);
      edge_d = (stored_d <= EDGE_LO) || (stored_d >= EDGE_HI);
    end

    always_ff @(posedge CORE_CLK) begin
      if (brst) begin
        hf_q <= 1'b0;
        edge_q <= 1'b1;
      end else begin
        hf_q <= hf_d;
        edge_q <= edge_d;
      end
    end

    assign level[g] = wptr_q - rptr_q;
    assign ev[g*EV_STRIDE+EV_OVF] = push_tick & push_en & ~ir_q & ~brst;
    assign ev[g*EV_STRIDE+EV_UNF] = pop_tick & pop_en & ~or_q & ~brst;
    assign ev[g*EV_STRIDE+EV_HALF] = hf_d & ~hf_q & ~brst;
    assign ev[g*EV_STRIDE+EV_FULL] = ir_q & ~ir_d & ~brst;
    assign flags[g*FLG_STRIDE+FLG_SPACE] = ir_q;
    assign flags[g*FLG_STRIDE+FLG_OUT] = or_q;
    assign flags[g*FLG_STRIDE+FLG_HALF] = hf_q;
    assign flags[g*FLG_STRIDE+FLG_EDGE] = edge_q;

    assign BUF_OUT[g].data_out = dout_q;
    assign BUF_OUT[g].out_ready_flag = or_q;
    assign BUF_OUT[g].space_avail_flag = ir_q;
    assign BUF_OUT[g].half_level_flag = hf_q;
    assign BUF_OUT[g].near_edge_flag = edge_q;
  end

  // APB slave: data is prepared in setup, access lasts one cycle
  logic setup;
  logic access;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  dsf_ev_t stat_q;
  dsf_ev_t stat_d;
  dsf_ev_t en_q;
  dsf_ev_t en_d;
  dsf_ev_t clr;
  logic irq_q;
  logic irq_d;

  assign setup = APB_REQ.psel & ~APB_REQ.penable;
  assign access = APB_REQ.psel & APB_REQ.penable & pready_q;

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = setup;
    ctrl_d = ctrl_q;
    en_d = en_q;
    clr = '0;
    if (setup) begin
      prdata_d = '0;
      if (APB_REQ.paddr == REG_CTRL) begin
        prdata_d[NUM_BUF-1:0] = ctrl_q;
      end else if (APB_REQ.paddr == REG_FLAGS) begin
        prdata_d[NUM_BUF*FLG_STRIDE-1:0] = flags;
      end else if (APB_REQ.paddr == REG_EV_STAT) begin
        prdata_d[7:0] = stat_q;
      end else if (APB_REQ.paddr == REG_EV_CLR) begin
        prdata_d = '0;
      end else if (APB_REQ.paddr == REG_EV_EN) begin
        prdata_d[7:0] = en_q;
      end else if (APB_REQ.paddr == REG_LEVEL) begin
        prdata_d[PW-1:0] = level[0];
        prdata_d[LVL_STRIDE +: PW] = level[1];
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (access && APB_REQ.pwrite) begin
      if (APB_REQ.paddr == REG_CTRL) begin
        ctrl_d = APB_REQ.pwdata[NUM_BUF-1:0];
      end else if (APB_REQ.paddr == REG_EV_CLR) begin
        clr = APB_REQ.pwdata[7:0];
      end else if (APB_REQ.paddr == REG_EV_EN) begin
        en_d = APB_REQ.pwdata[7:0];
      end
    end
    // A new event wins over a clear in the same cycle
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_q & en_q);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      ctrl_q <= CTRL_RST_VAL;
      stat_q <= '0;
      en_q <= EV_EN_RST_VAL;
      irq_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      en_q <= en_d;
      irq_q <= irq_d;
    end
  end

  assign APB_RSP.prdata = prdata_q;
  assign APB_RSP.pready = pready_q;
  assign APB_RSP.pslverr = pslverr_q;
  assign IRQ = irq_q;
endmodule

// ===== verification/dsf_chk.sv
`timescale 1ns/1ps
module dsf_chk
  import dsf_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEF
) (
  // Core clock and reset
  input logic CORE_CLK,
  input logic RST,
  // Register bus
  input dsf_apb_req_s APB_REQ,
  input dsf_apb_rsp_s APB_RSP,
  // Buffer pins and interrupt
  input dsf_pin_in_s BUF_IN [NUM_BUF],
  input dsf_pin_out_s BUF_OUT [NUM_BUF],
  input logic IRQ
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  apb_answer_a:
  assert property (APB_REQ.psel && !APB_REQ.penable |=> APB_RSP.pready)
    else $error("No ready in access cycle");
  apb_pulse_a:
  assert property (APB_RSP.pready |=> !APB_RSP.pready)
    else $error("Ready held past one cycle");
  apb_err_a:
  assert property (APB_RSP.pslverr |-> APB_RSP.pready)
    else $error("Error without ready");
  irq_rst_a:
  assert property ($fell(RST) |-> !IRQ)
    else $error("Interrupt set out of reset");
  for (genvar g = 0; g < NUM_BUF; g++) begin : g_buf
    logic [3:0] f;
    logic rn;
    assign f = {BUF_OUT[g].near_edge_flag, BUF_OUT[g].half_level_flag,
                BUF_OUT[g].out_ready_flag, BUF_OUT[g].space_avail_flag};
    assign rn = BUF_IN[g].reset_n;
    rst_flags_a:
    assert property ($fell(RST) |-> f == 4'h8)
      else $error("Flags wrong out of core reset");
    pin_rst_a:
    assert property ((!rn) [*6] |=> f == 4'h8)
      else $error("Flags wrong in buffer reset");
    keep_space_a:
    assert property ((f[0] && rn && !BUF_IN[g].push_enable) [*6] |=> f[0])
      else $error("Space flag fell with no push");
    keep_out_a:
    assert property ((f[1] && rn && !BUF_IN[g].pop_enable) [*6]
      |=> f[1] && $stable(BUF_OUT[g].data_out))
      else $error("Output moved with no pop");
    full_lvl_a:
    assert property (f[1] && rn && !f[0] |=> f[3] && f[2])
      else $error("Level flags wrong when full");
    empty_lvl_a:
    assert property (!f[1] |-> f[3] && !f[2])
      else $error("Level flags wrong when empty");
  end
endmodule

bind dsf_top dsf_chk #(.DEPTH(DEPTH)) u_chk (.CORE_CLK(CORE_CLK),
  .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .BUF_IN(BUF_IN),
  .BUF_OUT(BUF_OUT), .IRQ(IRQ));

// ===== verification/dsf_far_model.sv
`timescale 1ns/1ps
module dsf_far_model
  import dsf_pkg::*;
#(
  parameter int WH = 5,
  parameter int RH = 5,
  parameter int RO = 0
) (
  // Core timing and bench controls
  input logic clk,
  input logic rst_n,
  input logic push_on,
  input logic pop_on,
  input logic din,
  // Pins of one buffer
  output dsf_pin_in_s pins,
  input dsf_pin_out_s flags,
  // Transfers the buffer accepted
  output logic pushed,
  output logic push_bit,
  output logic popped,
  output logic pop_bit
);
  int wc = 0;
  int rc = RO;
  initial begin
    pins = '0;
    {pushed, push_bit, popped, pop_bit} = 4'h0;
  end
  // Clocks run free, counted in core cycles
  always @(posedge clk) begin
    wc <= (wc + 1) % (2 * WH);
    rc <= (rc + 1) % (2 * RH);
    pins.push_clock <= (wc + 1) % (2 * WH) >= WH;
    pins.pop_clock <= (rc + 1) % (2 * RH) >= RH;
    pins.reset_n <= rst_n;
    // Flags only move at ticks, so their level at the pin rise decides
    pushed <= wc == WH - 1 && pins.push_enable && flags.space_avail_flag;
    push_bit <= pins.data_in;
    popped <= rc == RH - 1 && pins.pop_enable && flags.out_ready_flag;
    pop_bit <= flags.data_out;
    // Mid low phase, well clear of the sampling rise
    if (wc == 1) begin
      pins.push_enable <= push_on;
      pins.data_in <= din;
    end
    if (rc == 1) pins.pop_enable <= pop_on;
  end
endmodule

// ===== verification/dual_serial_async_fifo_tb_top.sv
`timescale 1ns/1ps
module dual_serial_async_fifo_tb_top;
  import dsf_pkg::*;
  localparam int DEP = DEPTH_SMALL;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  dsf_apb_req_s req = '0;
  dsf_apb_rsp_s rsp;
  dsf_pin_in_s pin_in [NUM_BUF];
  dsf_pin_out_s pin_out [NUM_BUF];
  logic irq;
  logic [1:0] rst_n = 2'h0;
  logic [1:0] push_on = 2'h0;
  logic [1:0] pop_on = 2'h0;
  logic [1:0] din = 2'h0;
  logic [1:0] pushed, pbit, popped, qbit;
  logic mq [NUM_BUF][$];
  logic [31:0] rd;
  logic err;
  logic b;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #10 CORE_CLK = ~CORE_CLK;

  dsf_top #(.DEPTH(DEP)) dut (.CORE_CLK(CORE_CLK), .RST(RST),
    .APB_REQ(req), .APB_RSP(rsp), .BUF_IN(pin_in), .BUF_OUT(pin_out),
    .IRQ(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Buffer 0 pop rises sit half a period after push rises
  for (genvar g = 0; g < NUM_BUF; g++) begin : g_far
    dsf_far_model #(.WH(5 - g), .RH(5 + g), .RO(5 - 5 * g)) u_far (
      .clk(CORE_CLK), .rst_n(rst_n[g]), .push_on(push_on[g]),
      .pop_on(pop_on[g]), .din(din[g]), .pins(pin_in[g]),
      .flags(pin_out[g]), .pushed(pushed[g]), .push_bit(pbit[g]),
      .popped(popped[g]), .pop_bit(qbit[g]));
    always @(posedge CORE_CLK) begin
      if (pushed[g]) mq[g].push_back(pbit[g]);
      if (popped[g])
        chk_bit(qbit[g], mq[g].size() ? mq[g].pop_front() : 1'bx);
    end
  end

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int t;
    t = 0;
    @(posedge CORE_CLK);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge CORE_CLK);
    req.penable <= 1'b1;
    do @(posedge CORE_CLK); while (rsp.pready !== 1'b1 && ++t < 20);
    if (t == 20) begin
      fail_count++;
      end_sim();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  function automatic logic [3:0] flg(input int g);
    return {pin_out[g].near_edge_flag, pin_out[g].half_level_flag,
            pin_out[g].out_ready_flag, pin_out[g].space_avail_flag};
  endfunction

  task automatic lvl_chk();
    int st;
    logic [3:0] f;
    logic [31:0] lv;
    apb(1'b0, REG_LEVEL, 32'h0);
    lv = rd;
    apb(1'b0, REG_FLAGS, 32'h0);
    for (int g = 0; g < NUM_BUF; g++) begin
      st = mq[g].size() > 0 ? mq[g].size() - 1 : 0;
      f = {st <= EDGE_GAP || st >= DEP - EDGE_GAP, st >= DEP / 2,
           mq[g].size() > 0, st < DEP};
      chk(32'(lv[g*LVL_STRIDE +: 9]), st);
      chk(32'(flg(g)), 32'(f));
      chk(32'(rd[g*FLG_STRIDE +: 4]), 32'(f));
    end
  endtask

  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(76));
    fork
      forever @(posedge CORE_CLK) din <= 2'($urandom);
    join_none
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b0;
    repeat (50) @(posedge CORE_CLK);
    chk(32'(flg(0)), 32'h8);
    chk(32'(flg(1)), 32'h8);
    rdc(REG_FLAGS, 32'h88);
    rdc(REG_EV_EN, 32'h0);
    rdc(REG_CTRL, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk_bit(err, 1'b1);
    @(posedge pin_in[0].push_clock);
    repeat (2) @(posedge CORE_CLK);
    rst_n <= 2'h3;
    for (int k = 0; k < 2; k++) begin
      @(posedge pin_in[0].push_clock);
      repeat (7) @(posedge CORE_CLK);
      chk_bit(pin_out[0].space_avail_flag, k == 1);
    end
    pop_on <= 2'h1;
    push_on <= 2'h1;
    @(posedge CORE_CLK iff pushed[0]);
    b = pbit[0];
    push_on <= 2'h0;
    for (int k = 0; k < 3; k++) begin
      @(posedge pin_in[0].pop_clock);
      repeat (7) @(posedge CORE_CLK);
      chk_bit(pin_out[0].out_ready_flag, k == 2);
    end
    chk_bit(pin_out[0].data_out, b);
    repeat (40) @(posedge CORE_CLK);
    pop_on <= 2'h0;
    repeat (40) @(posedge CORE_CLK);
    apb(1'b1, REG_EV_CLR, 32'hff);
    apb(1'b1, REG_EV_EN, 32'hff);
    push_on <= 2'h3;
    for (int t = 0; t < 2000 && (pin_out[0].space_avail_flag
         | pin_out[1].space_avail_flag); t++)
      @(posedge CORE_CLK);
    // Keep pushing into the full buffers; all of it must be refused
    repeat (100) @(posedge CORE_CLK);
    push_on <= 2'h0;
    repeat (40) @(posedge CORE_CLK);
    lvl_chk();
    rdc(REG_EV_STAT, 32'hdd);
    chk_bit(irq, 1'b1);
    apb(1'b1, REG_EV_EN, 32'h0);
    repeat (3) @(posedge CORE_CLK);
    chk_bit(irq, 1'b0);
    apb(1'b1, REG_EV_EN, 32'hff);
    apb(1'b1, REG_EV_CLR, 32'hff);
    repeat (3) @(posedge CORE_CLK);
    chk_bit(irq, 1'b0);
    rdc(REG_EV_STAT, 32'h0);
    while (mq[0].size() + mq[1].size() > 0 && cyc < 30000) begin
      pop_on <= {mq[0].size() == 0, 1'b1};
      repeat ($urandom_range(60, 10)) @(posedge CORE_CLK);
      pop_on <= 2'h0;
      repeat (40) @(posedge CORE_CLK);
      lvl_chk();
    end
    // Bits left behind mean the drain ran out of time
    if (mq[0].size() + mq[1].size() > 0) fail_count++;
    end_sim();
  end
endmodule
